// ### hdl/ptd_regs.sv
/*
  Register bank for the 10M receiver control, built-in self-test, cable
  diagnostic and transceiver reset control. Assumes all event inputs are
  synchronous to core_clk; software uses a one-cycle strobe port with read
  data returned the following cycle.
*/
`timescale 1ns/1ps

// Function
// - Bit 13 lowers 10M receive threshold
// - Bits 12:9 select squelch, reset 0000
// - Bit 7 stops link pulses
// - Bit 4 reports inverted polarity
// - Receiver reg read clears polarity, mirror
// - Bit 0 disables jabber in 10M
// - Bits 15:8 count self-test byte errors
// - Writing bit 15 captures, clears counter
// - Mode zero saturates counter at 0xFF
// - Bits 7:0 gap, default 0x7D
// - Bits 10:0 packet length, default 0x5EE
// - Bit 15 write launches cable measurement
// - Start bit clears when done rises
// - Bit 1 reads cable measurement done
// - Bit 0 reads cable measurement failed
// - Bit 15 full reset, self-clearing
// - Bit 14 digital restart, self-clearing
module ptd_regs (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic [4:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [15:0]           reg_rdata,
  input  wire logic                  pol_inverted,
  input  wire logic                  bist_err_byte,
  input  wire logic                  cable_done,
  input  wire logic                  cable_fail,
  output ptd_pkg::ptd_rx_cfg_t       rx_cfg,
  output ptd_pkg::ptd_bist_cfg_t     bist_cfg,
  output logic                       cable_start,
  output logic                       status_pol_mirror,
  output logic                       soft_reset,
  output logic                       dig_restart,
  output logic                       irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ptd_pkg::ptd_rx_cfg_t   rx_q;        // Receiver settings
  ptd_pkg::ptd_bist_cfg_t bist_q;      // Self-test settings
  logic                   pol_q;       // Sticky polarity flag
  logic [7:0]             err_cnt_q;   // Running error counter
  logic [7:0]             err_snap_q;  // Count shown to software
  logic                   start_q;     // Cable measurement running
  logic                   done_q;      // Measurement complete
  logic                   fail_q;      // Measurement failed
  logic                   soft_q;      // Soft reset pulse
  logic [2:0]             rst_cnt_q;   // Restart pulse counter
  logic                   dig_q;       // Digital restart pulse
  logic [ptd_pkg::IRQ_W-1:0] ist_q;    // Interrupt status
  logic [ptd_pkg::IRQ_W-1:0] imsk_q;   // Interrupt mask
  logic [15:0]            rdata_q;     // Read data register
  logic                   irq_q;       // Interrupt output register
  logic                   any_rst;     // Full reset, hard or soft

  // Decoded strobes
  logic wr_rx;
  logic wr_b1;
  logic wr_b2;
  logic wr_cab;
  logic wr_rst;
  logic rd_rx;
  logic rd_ist;

  assign wr_rx  = reg_wr && (reg_addr == ptd_pkg::ADDR_RXCTL);
  assign wr_b1  = reg_wr && (reg_addr == ptd_pkg::ADDR_BIST1);
  assign wr_b2  = reg_wr && (reg_addr == ptd_pkg::ADDR_BIST2);
  assign wr_cab = reg_wr && (reg_addr == ptd_pkg::ADDR_CABLE);
  assign wr_rst = reg_wr && (reg_addr == ptd_pkg::ADDR_RSTCTL);
  assign rd_rx  = reg_rd && (reg_addr == ptd_pkg::ADDR_RXCTL);
  assign rd_ist = reg_rd && (reg_addr == ptd_pkg::ADDR_IRQ_ST);

  // Soft reset acts like the hardware reset one cycle after the write
  assign any_rst = sys_rst || soft_q;

  // ----------------------------------------------------------------
  // Receiver control
  // ----------------------------------------------------------------
  // Reserved bits are simply not stored
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      rx_q.low_thresh     <= 1'b0;
      rx_q.squelch        <= ptd_pkg::RST_SQUELCH;
      rx_q.link_pulse_off <= 1'b0;
      rx_q.jabber_off     <= 1'b0;
    end else if (wr_rx) begin
      rx_q.low_thresh     <= reg_wdata[ptd_pkg::RX_LOWTH_BIT];
      rx_q.squelch        <= reg_wdata[ptd_pkg::RX_SQ_LSB +: 4];
      rx_q.link_pulse_off <= reg_wdata[ptd_pkg::RX_LINKP_BIT];
      rx_q.jabber_off     <= reg_wdata[ptd_pkg::RX_JAB_BIT];
    end
  end

  // Polarity flag: a new detection wins over the read that clears it
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      pol_q <= 1'b0;
    end else if (pol_inverted) begin
      pol_q <= 1'b1;
    end else if (rd_rx) begin
      pol_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Self-test configuration and error count
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      bist_q.gap       <= ptd_pkg::RST_GAP;
      bist_q.pkt_len   <= ptd_pkg::RST_PKT_LEN;
      bist_q.wrap_mode <= 1'b0;
    end else begin
      if (wr_b1) begin
        bist_q.gap <= reg_wdata[7:0];
      end
      if (wr_b2) begin
        bist_q.pkt_len <= reg_wdata[10:0];
      end
      if (reg_wr && (reg_addr == ptd_pkg::ADDR_MODE)) begin
        bist_q.wrap_mode <= reg_wdata[0];
      end
    end
  end

  // Counter: capture-and-clear has priority; the error in the same
  // cycle is counted into the fresh count so it is not lost
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      err_cnt_q  <= 8'h00;
      err_snap_q <= 8'h00;
    end else if (wr_b1 && reg_wdata[ptd_pkg::B1_LOCK_BIT]) begin
      err_snap_q <= err_cnt_q;
      err_cnt_q  <= bist_err_byte ? 8'h01 : 8'h00;
    end else if (bist_err_byte) begin
      if (bist_q.wrap_mode || (err_cnt_q != ptd_pkg::ERR_SAT)) begin
        err_cnt_q <= err_cnt_q + 8'h01;
      end else begin
        err_cnt_q <= err_cnt_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Cable diagnostic
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      start_q <= 1'b0;
      done_q  <= 1'b0;
      fail_q  <= 1'b0;
    end else if (start_q && cable_done) begin
      start_q <= 1'b0;
      done_q  <= 1'b1;
      fail_q  <= cable_fail;
    end else if (wr_cab && reg_wdata[ptd_pkg::CAB_START_BIT]) begin
      start_q <= 1'b1;
      done_q  <= 1'b0;
      fail_q  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Reset control
  // ----------------------------------------------------------------
  // Soft reset is a one-cycle self-clearing pulse
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= wr_rst && reg_wdata[ptd_pkg::RST_SOFT_BIT];
    end
  end

  // Digital restart: a short pulse outward, registers kept
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      rst_cnt_q <= 3'd0;
      dig_q     <= 1'b0;
    end else if (wr_rst && reg_wdata[ptd_pkg::RST_DIG_BIT]) begin
      rst_cnt_q <= 3'(ptd_pkg::RESTART_CYC - 1);
      dig_q     <= 1'b1;
    end else if (rst_cnt_q != 3'd0) begin
      rst_cnt_q <= rst_cnt_q - 3'd1;
    end else begin
      dig_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [ptd_pkg::IRQ_W-1:0] ev;
  assign ev = {start_q && cable_done && cable_fail,
               start_q && cable_done,
               pol_inverted};

  // Sticky status, cleared by a read; new event wins
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      ist_q <= '0;
    end else begin
      ist_q <= (rd_ist ? '0 : ist_q) | ev;
    end
  end

  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      imsk_q <= '0;
    end else if (reg_wr && (reg_addr == ptd_pkg::ADDR_IRQ_MSK)) begin
      imsk_q <= reg_wdata[ptd_pkg::IRQ_W-1:0];
    end
  end

  // A set mask bit blocks its status bit from the interrupt line
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((rd_ist ? '0 : ist_q) | ev) & ~imsk_q);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped addresses and reserved bits return zero
  always_ff @(posedge core_clk) begin
    if (any_rst) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ptd_pkg::ADDR_RXCTL:   rdata_q <= {2'b00, rx_q.low_thresh,
                                  rx_q.squelch, 1'b0, rx_q.link_pulse_off,
                                  2'b00, pol_q, 3'b000,
                                  rx_q.jabber_off};
        ptd_pkg::ADDR_BIST1:   rdata_q <= {err_snap_q, bist_q.gap};
        ptd_pkg::ADDR_BIST2:   rdata_q <= {5'h00, bist_q.pkt_len};
        ptd_pkg::ADDR_CABLE:   rdata_q <= {start_q, 13'h0000,
                                  done_q, fail_q};
        ptd_pkg::ADDR_RSTCTL:  rdata_q <= 16'h0000; // Self-clearing bits
        ptd_pkg::ADDR_IRQ_ST:  rdata_q <= {13'h0000, ist_q};
        ptd_pkg::ADDR_IRQ_MSK: rdata_q <= {13'h0000, imsk_q};
        ptd_pkg::ADDR_MODE:    rdata_q <= {15'h0000, bist_q.wrap_mode};
        default:               rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata         = rdata_q;
  assign rx_cfg            = rx_q;
  assign bist_cfg          = bist_q;
  assign cable_start       = start_q;
  assign status_pol_mirror = pol_q;
  assign soft_reset        = soft_q;
  assign dig_restart       = dig_q;
  assign irq               = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_POL_CLR: assert property (@(posedge core_clk) disable iff (sys_rst)
    rd_rx && !pol_inverted && !soft_q |=> !pol_q)
    else $error("polarity flag not cleared by read");

  AST_POL_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
    pol_inverted && !soft_q |=> pol_q && status_pol_mirror)
    else $error("polarity flag not set");

  AST_SAT: assert property (@(posedge core_clk) disable iff (sys_rst)
    !bist_q.wrap_mode && err_cnt_q == 8'hff && !wr_b1 && !soft_q
    |=> err_cnt_q == 8'hff)
    else $error("error counter left saturation");

  AST_CNT: assert property (@(posedge core_clk) disable iff (sys_rst)
    bist_err_byte && !wr_b1 && !soft_q && err_cnt_q != 8'hff
    |=> err_cnt_q == $past(err_cnt_q) + 8'h01)
    else $error("error counter missed a byte");

  AST_LOCK: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_b1 && reg_wdata[15] && !soft_q
    |=> err_snap_q == $past(err_cnt_q) && err_cnt_q <= 8'h01)
    else $error("capture and clear failed");

  AST_DONE: assert property (@(posedge core_clk) disable iff (sys_rst)
    start_q && cable_done && !soft_q |=> !cable_start && done_q)
    else $error("start not cleared on done");

  AST_START: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_cab && reg_wdata[15] && !start_q && !soft_q
    |=> cable_start && !done_q)
    else $error("cable measurement not launched");

  AST_SOFT: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_rst && reg_wdata[15] |=> soft_reset ##1
    (!soft_reset && bist_cfg.gap == 8'h7d
     && bist_cfg.pkt_len == 11'h5ee))
    else $error("soft reset did not restore defaults");

  AST_DIG: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_rst && reg_wdata[14] && !reg_wdata[15] && !soft_q
    |=> dig_restart [*4] ##1 !dig_restart)
    else $error("digital restart pulse wrong length");

endmodule : ptd_regs

// ### common/ptd_pkg.sv
/*
  Shared constants and carriers for the PHY test and diagnostic register
  slice. Assumes a single 100 MHz core clock and a plain register port.
*/
package ptd_pkg;

  // ----------------------------------------------------------------
  // Register addresses (word index on the management port)
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_RXCTL   = 5'h1a; // ten_meg_rx_control_status
  localparam logic [4:0] ADDR_BIST1   = 5'h1b; // self_test_errors_and_gap
  localparam logic [4:0] ADDR_BIST2   = 5'h1c; // self_test_packet_length
  localparam logic [4:0] ADDR_CABLE   = 5'h1e; // cable_check_control
  localparam logic [4:0] ADDR_RSTCTL  = 5'h1f; // transceiver_reset_control
  localparam logic [4:0] ADDR_IRQ_ST  = 5'h14; // interrupt status
  localparam logic [4:0] ADDR_IRQ_MSK = 5'h15; // interrupt mask
  localparam logic [4:0] ADDR_MODE    = 5'h16; // error-counter mode

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RX_LOWTH_BIT   = 13;
  localparam int RX_SQ_LSB      = 9;
  localparam int RX_LINKP_BIT   = 7;
  localparam int RX_POL_BIT     = 4;
  localparam int RX_JAB_BIT     = 0;
  localparam int B1_CNT_LSB     = 8;
  localparam int B1_LOCK_BIT    = 15;
  localparam int CAB_START_BIT  = 15;
  localparam int CAB_DONE_BIT   = 1;
  localparam int CAB_FAIL_BIT   = 0;
  localparam int RST_SOFT_BIT   = 15;
  localparam int RST_DIG_BIT    = 14;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [3:0]  RST_SQUELCH = 4'h0;
  localparam logic [7:0]  RST_GAP     = 8'h7d;
  localparam logic [10:0] RST_PKT_LEN = 11'h5ee;
  localparam logic [7:0]  ERR_SAT     = 8'hff;
  localparam logic [3:0]  SQ_MAX      = 4'h8;

  // Interrupt status bits
  localparam int IRQ_POL  = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_FAIL = 2;
  localparam int IRQ_W    = 3;

  // Restart pulse length in cycles
  localparam int RESTART_CYC = 4;

  // Receiver configuration carried to the analogue front end
  typedef struct packed {
    logic       low_thresh;   // Lower 10M threshold
    logic [3:0] squelch;      // Squelch code
    logic       link_pulse_off; // Stop link pulses
    logic       jabber_off;   // Jabber disabled (10M only)
  } ptd_rx_cfg_t;

  // Self-test configuration
  typedef struct packed {
    logic [7:0]  gap;         // Inter-packet gap, bytes
    logic [10:0] pkt_len;     // Packet length, bytes
    logic        wrap_mode;   // 1: counter wraps, 0: saturates
  } ptd_bist_cfg_t;

endpackage : ptd_pkg

// ### tb/tb_ptd_regs.sv
/*
  Self-checking bench for the test and diagnostic register slice.
  Assumes one 100 MHz clock, a synchronous active-high reset, and that a
  set mask bit blocks the matching interrupt status bit.
*/
`timescale 1ns/1ps
module tb_ptd_regs;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic                   core_clk;          // Core clock
  logic                   sys_rst;           // Sync reset
  logic [4:0]             reg_addr;          // Register index
  logic [15:0]            reg_wdata;         // Write data
  logic                   reg_wr;            // Write strobe
  logic                   reg_rd;            // Read strobe
  logic [15:0]            reg_rdata;         // Read data
  logic                   pol_inverted;      // Polarity event
  logic                   bist_err_byte;     // Errored byte
  logic                   cable_done;        // Measurement done
  logic                   cable_fail;        // Measurement failed
  ptd_pkg::ptd_rx_cfg_t   rx_cfg;            // Receiver settings
  ptd_pkg::ptd_bist_cfg_t bist_cfg;          // Self-test settings
  logic                   cable_start;       // Measurement running
  logic                   status_pol_mirror; // Status mirror
  logic                   soft_reset;        // Full reset pulse
  logic                   dig_restart;       // Restart pulse
  logic                   irq;               // Interrupt line
  int                     miscompares;       // Mismatch count
  int                     n_tests;           // Comparison count
  int                     hi;                // Pulse width count

  ptd_regs ptd_regs_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pol_inverted(pol_inverted),
    .bist_err_byte(bist_err_byte), .cable_done(cable_done),
    .cable_fail(cable_fail), .rx_cfg(rx_cfg), .bist_cfg(bist_cfg),
    .cable_start(cable_start), .status_pol_mirror(status_pol_mirror),
    .soft_reset(soft_reset), .dig_restart(dig_restart), .irq(irq));

  // ------------------------------------------------------------
  // Shared bus and compare tasks
  // ------------------------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write strobe, released at the edge that takes it;
  // returns just past that edge so callers see the updated outputs
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd

  // Hold an event input high for n sampled cycles
  task errs(input int n);
    @(posedge core_clk);
    bist_err_byte <= 1'b1;
    repeat (n) @(posedge core_clk);
    bist_err_byte <= 1'b0;
  endtask : errs

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_defaults;
    rd(ptd_pkg::ADDR_RXCTL, 16'h0000);
    rd(ptd_pkg::ADDR_BIST1, 16'h007d);
    rd(ptd_pkg::ADDR_BIST2, 16'h05ee);
    rd(ptd_pkg::ADDR_CABLE, 16'h0000);
    chk({5'h00, bist_cfg.pkt_len}, 16'h05ee);
  endtask : t_defaults

  // All ones: reserved bits must read zero and drive nothing
  task t_rxctl;
    wr(ptd_pkg::ADDR_RXCTL, 16'hffff);
    rd(ptd_pkg::ADDR_RXCTL, 16'h3e81);
    chk({9'h000, rx_cfg}, 16'h007f);
    chk({15'h0, rx_cfg.jabber_off}, 16'h0001);
    wr(ptd_pkg::ADDR_RXCTL, 16'h1000);
    chk({12'h000, rx_cfg.squelch}, 16'h0008);
    chk({14'h0, rx_cfg.link_pulse_off, rx_cfg.jabber_off}, 16'h0);
    rd(ptd_pkg::ADDR_BIST2, 16'h05ee);
    wr(ptd_pkg::ADDR_BIST2, 16'hffff);
    rd(ptd_pkg::ADDR_BIST2, 16'h07ff);
    rd(5'h10, 16'h0000);
  endtask : t_rxctl

  // Flag is cleared by the read that reports it
  task t_polarity;
    @(posedge core_clk);
    pol_inverted <= 1'b1;
    @(posedge core_clk);
    pol_inverted <= 1'b0;
    #1;
    chk({15'h0, status_pol_mirror}, 16'h0001);
    rd(ptd_pkg::ADDR_RXCTL, 16'h1010);
    chk({15'h0, status_pol_mirror}, 16'h0000);
    rd(ptd_pkg::ADDR_RXCTL, 16'h1000);
    rd(ptd_pkg::ADDR_IRQ_ST, 16'h0001);
  endtask : t_polarity

  task t_errcount;
    errs(300);
    wr(ptd_pkg::ADDR_BIST1, 16'h8033);
    rd(ptd_pkg::ADDR_BIST1, 16'hff33);
    errs(3);
    wr(ptd_pkg::ADDR_BIST1, 16'h8033);
    rd(ptd_pkg::ADDR_BIST1, 16'h0333);
    wr(ptd_pkg::ADDR_MODE, 16'h0001);
    chk({15'h0, bist_cfg.wrap_mode}, 16'h0001);
    rd(ptd_pkg::ADDR_MODE, 16'h0001);
    errs(257);
    wr(ptd_pkg::ADDR_BIST1, 16'h8033);
    rd(ptd_pkg::ADDR_BIST1, 16'h0133);
    chk({8'h00, bist_cfg.gap}, 16'h0033);
  endtask : t_errcount

  // Measurement with failure, then interrupt mask and clear
  task t_cable;
    wr(ptd_pkg::ADDR_CABLE, 16'h8000);
    rd(ptd_pkg::ADDR_CABLE, 16'h8000);
    chk({15'h0, cable_start}, 16'h0001);
    @(posedge core_clk);
    cable_done <= 1'b1;
    cable_fail <= 1'b1;
    @(posedge core_clk);
    cable_done <= 1'b0;
    cable_fail <= 1'b0;
    #1;
    chk({15'h0, cable_start}, 16'h0000);
    rd(ptd_pkg::ADDR_CABLE, 16'h0003);
    chk({15'h0, irq}, 16'h0001);
    wr(ptd_pkg::ADDR_IRQ_MSK, 16'h0007);
    @(posedge core_clk);
    #1;
    chk({15'h0, irq}, 16'h0000);
    wr(ptd_pkg::ADDR_IRQ_MSK, 16'h0000);
    rd(ptd_pkg::ADDR_IRQ_ST, 16'h0006);
    rd(ptd_pkg::ADDR_IRQ_ST, 16'h0000);
    @(posedge core_clk);
    #1;
    chk({15'h0, irq}, 16'h0000);
    wr(ptd_pkg::ADDR_CABLE, 16'h8000);
    @(posedge core_clk);
    cable_done <= 1'b1;
    @(posedge core_clk);
    cable_done <= 1'b0;
    rd(ptd_pkg::ADDR_CABLE, 16'h0002);
  endtask : t_cable

  // Restart keeps settings; full reset restores defaults
  task t_resets;
    wr(ptd_pkg::ADDR_BIST2, 16'h0123);
    wr(ptd_pkg::ADDR_RSTCTL, 16'h4000);
    hi = 0;
    repeat (8) begin
      #1;
      hi += int'(dig_restart === 1'b1);
      @(posedge core_clk);
    end
    chk(16'(hi), 16'(ptd_pkg::RESTART_CYC));
    rd(ptd_pkg::ADDR_BIST2, 16'h0123);
    rd(ptd_pkg::ADDR_RSTCTL, 16'h0000);
    wr(ptd_pkg::ADDR_RXCTL, 16'h3e81);
    wr(ptd_pkg::ADDR_RSTCTL, 16'h8000);
    #1;
    chk({15'h0, soft_reset}, 16'h0001);
    @(posedge core_clk);
    #1;
    chk({15'h0, soft_reset}, 16'h0000);
    rd(ptd_pkg::ADDR_BIST2, 16'h05ee);
    rd(ptd_pkg::ADDR_RXCTL, 16'h0000);
    rd(ptd_pkg::ADDR_BIST1, 16'h007d);
  endtask : t_resets

  // ------------------------------------------------------------
  // Verdict, clock, watchdog and main sequence
  // ------------------------------------------------------------
  task complete_run;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Whole run is near 670 cycles; far past that means a hang
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end

  initial begin
    miscompares   = 0;
    n_tests       = 0;
    sys_rst       = 1'b1;
    reg_addr      = 5'h00;
    reg_wdata     = 16'h0000;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    pol_inverted  = 1'b0;
    bist_err_byte = 1'b0;
    cable_done    = 1'b0;
    cable_fail    = 1'b0;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_defaults();
    t_rxctl();
    t_polarity();
    t_errcount();
    t_cable();
    t_resets();
    complete_run();
  end
endmodule : tb_ptd_regs
